// ### rtl/dtp_pkg.sv
// Shared constants and types for the down timer with PWM and buzzer
package dtp_pkg;
  // Register byte offsets on the Avalon-MM slave
  localparam logic [5:0] DTP_OFF_CTRL_ONE  = 6'h00;
  localparam logic [5:0] DTP_OFF_CTRL_TWO  = 6'h04;
  localparam logic [5:0] DTP_OFF_UPPER     = 6'h08;
  localparam logic [5:0] DTP_OFF_RELOAD_LO = 6'h0c;
  localparam logic [5:0] DTP_OFF_DUTY_LO   = 6'h10;
  localparam logic [5:0] DTP_OFF_PRESCALE  = 6'h14;
  localparam logic [5:0] DTP_OFF_BUZZER    = 6'h18;
  localparam logic [5:0] DTP_OFF_IRQ_FLAG  = 6'h1c;
  localparam logic [5:0] DTP_OFF_IRQ_EN    = 6'h20;
  localparam logic [5:0] DTP_OFF_PROC_TWO  = 6'h24;
  localparam logic [5:0] DTP_OFF_PAD_OPT   = 6'h28;

  // Field positions in timer_control_one
  localparam int DTP_C1_RUN       = 0;
  localparam int DTP_C1_RELOAD    = 1;
  localparam int DTP_C1_ONE_SHOT  = 2;
  localparam int DTP_C1_TOGGLE_EN = 5;
  localparam int DTP_C1_PWM_LOW   = 6;
  localparam int DTP_C1_PWM_EN    = 7;
  // Field positions in timer_control_two
  localparam int DTP_C2_EXT_SRC   = 5;
  localparam int DTP_C2_FALL_EDGE = 4;
  localparam int DTP_C2_PRE_EN_N  = 3;
  // Field positions in upper_bits_register
  localparam int DTP_UP_RELOAD_HI = 4;
  localparam int DTP_UP_DUTY_HI   = 0;
  // Field positions in buzzer, flag, enable and processor registers
  localparam int DTP_BZ_ENABLE    = 7;
  localparam int DTP_BZ_TIMER_SRC = 3;
  localparam int DTP_IRQ_BIT      = 3;
  localparam int DTP_GIE_BIT      = 7;

  // Reset values and counter limits
  localparam logic [7:0] DTP_RST_CTRL_TWO = 8'h08;
  localparam logic [9:0] DTP_COUNT_MAX    = 10'h3ff;
  localparam logic [9:0] DTP_COUNT_ZERO   = 10'h000;

  // One pad as level plus output enable
  typedef struct packed {
    logic level;
    logic enable;
  } dtp_pad_type;
endpackage

// ### rtl/dtp_down_timer_pwm_buzzer.sv
// Ten-bit down timer with prescaler, PWM and buzzer outputs
`timescale 1ns/1ps
module dtp_down_timer_pwm_buzzer
  import dtp_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic [5:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [3:0]  byteenable,
  input  wire logic [31:0] writedata,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  input  wire logic        externalCountClock,
  input  wire logic        comparatorOutEnable,
  input  wire logic        comparatorOut,
  output dtp_pad_type      portBPin4,
  output dtp_pad_type      portBPin1,
  output dtp_pad_type      portBPin3,
  output logic             underflowIrq
);

  // True when the low sel+1 bits of a divider count are all ones
  function automatic logic divTick(input logic [7:0] cnt,
                                   input logic [2:0] sel);
    logic [8:0] mask;
    mask = (9'h002 << sel) - 9'h001;
    return (({1'b0, cnt} & mask) == mask);
  endfunction

  logic [7:0] timerControlOne;
  logic [7:0] timerControlTwo;
  logic [7:0] upperBitsRegister;
  logic [7:0] pwmDutyLow;
  logic [7:0] buzzerControl;
  logic [9:0] reloadValue;
  logic       reloadPending;
  logic [9:0] activeDuty;
  logic [9:0] dutyBuffer;
  logic [9:0] count;
  logic [7:0] prescaleCount;
  logic [7:0] buzzerCount;
  logic       buzzerLevel;
  logic       toggleLevel;
  logic       underflowFlag;
  logic       underflowIrqEnable;
  logic       globalIrqEnable;
  logic       padOption;
  logic       extSync1;
  logic       extSync2;
  logic       extPrev;

  logic       busWrite;
  logic       runEnable;
  logic       sourceTick;
  logic       prescaleTick;
  logic       timerTick;
  logic       underflow;
  logic       buzzerSourceTick;
  logic       pwmLevel;
  logic [9:0] newReload;
  logic       wrCtrlOne;
  logic       wrReloadLow;
  logic       wrDutyLow;
  logic       wrFlag;

  // Write takes effect on the edge where waitrequest is seen low
  assign busWrite    = write && !waitrequest && byteenable[0];
  assign wrCtrlOne   = busWrite && (address == DTP_OFF_CTRL_ONE);
  assign wrReloadLow = busWrite && (address == DTP_OFF_RELOAD_LO);
  assign wrDutyLow   = busWrite && (address == DTP_OFF_DUTY_LO);
  assign wrFlag      = busWrite && (address == DTP_OFF_IRQ_FLAG);
  assign runEnable   = timerControlOne[DTP_C1_RUN];
  assign newReload   = {upperBitsRegister[DTP_UP_RELOAD_HI +: 2],
                        writedata[7:0]};

  // One-wait-state slave: waitrequest drops for one cycle per request
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      waitrequest <= 1'b1;
    end else begin
      waitrequest <= !((read || write) && waitrequest);
    end
  end

  // External clock pin synchroniser with edge history
  // Two flops against metastability; the third only remembers the level
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      extSync1 <= 1'b0;
      extSync2 <= 1'b0;
      extPrev  <= 1'b0;
    end else begin
      extSync1 <= externalCountClock;
      extSync2 <= extSync1;
      extPrev  <= extSync2;
    end
  end

  // Count source: every instruction clock or a chosen pin edge
  // Pin edges land three clocks after the pin moves
  always_comb begin
    if (!runEnable) begin
      sourceTick = 1'b0;
    end else if (timerControlTwo[DTP_C2_EXT_SRC]) begin
      if (timerControlTwo[DTP_C2_FALL_EDGE]) begin
        sourceTick = extPrev && !extSync2;
      end else begin
        sourceTick = !extPrev && extSync2;
      end
    end else begin
      sourceTick = 1'b1;
    end
  end

  // Prescaler is bypassed while its active-low enable is high
  assign prescaleTick = timerControlTwo[DTP_C2_PRE_EN_N] ? sourceTick :
    (sourceTick && divTick(prescaleCount, timerControlTwo[2:0]));
  assign timerTick = prescaleTick;
  assign underflow = timerTick && (count == DTP_COUNT_ZERO);

  // Prescaler count, cleared while not in use
  // Restarts from zero each time the prescaler is put back in
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      prescaleCount <= 8'h00;
    end else if (timerControlTwo[DTP_C2_PRE_EN_N]) begin
      prescaleCount <= 8'h00;
    end else if (sourceTick) begin
      prescaleCount <= prescaleCount + 8'h01;
    end
  end

  // Control one; one-shot underflow clears run unless software writes
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      timerControlOne <= 8'h00;
    end else if (wrCtrlOne) begin
      timerControlOne <= writedata[7:0];
    end else if (underflow && timerControlOne[DTP_C1_ONE_SHOT]) begin
      timerControlOne[DTP_C1_RUN] <= 1'b0;
    end
  end

  // Plain software configuration registers
  // Only byte lane zero carries register data
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      timerControlTwo    <= DTP_RST_CTRL_TWO;
      upperBitsRegister  <= 8'h00;
      pwmDutyLow         <= 8'h00;
      buzzerControl      <= 8'h00;
      underflowIrqEnable <= 1'b0;
      globalIrqEnable    <= 1'b0;
      padOption          <= 1'b0;
    end else if (busWrite) begin
      if (address == DTP_OFF_CTRL_TWO) begin
        timerControlTwo <= writedata[7:0];
      end else if (address == DTP_OFF_UPPER) begin
        upperBitsRegister <= writedata[7:0];
      end else if (address == DTP_OFF_DUTY_LO) begin
        pwmDutyLow <= writedata[7:0];
      end else if (address == DTP_OFF_BUZZER) begin
        buzzerControl <= writedata[7:0];
      end else if (address == DTP_OFF_IRQ_EN) begin
        underflowIrqEnable <= writedata[DTP_IRQ_BIT];
      end else if (address == DTP_OFF_PROC_TWO) begin
        globalIrqEnable <= writedata[DTP_GIE_BIT];
      end else if (address == DTP_OFF_PAD_OPT) begin
        padOption <= writedata[0];
      end
    end
  end

  // Reload buffer; a write while running waits for the underflow
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      reloadValue   <= DTP_COUNT_ZERO;
      reloadPending <= 1'b0;
    end else if (wrReloadLow) begin
      reloadValue   <= newReload;
      reloadPending <= runEnable;
    end else if (underflow) begin
      reloadPending <= 1'b0;
    end
  end

  // Down counter with immediate load when stopped
  // A low write meeting an underflow while running waits one more period
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      count <= DTP_COUNT_ZERO;
    end else if (wrReloadLow && !runEnable) begin
      count <= newReload;
    end else if (underflow) begin
      if (reloadPending || timerControlOne[DTP_C1_RELOAD] ||
          timerControlOne[DTP_C1_ONE_SHOT]) begin
        count <= reloadValue;
      end else begin
        count <= DTP_COUNT_MAX;
      end
    end else if (timerTick) begin
      count <= count - 10'h001;
    end
  end

  // Duty pair captured whole on the low write, so an underflow
  // between the two writes cannot apply half of a new duty
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      dutyBuffer <= DTP_COUNT_ZERO;
    end else if (wrDutyLow) begin
      dutyBuffer <= {upperBitsRegister[DTP_UP_DUTY_HI +: 2],
                     writedata[7:0]};
    end
  end

  // Active duty moves from the buffer only at underflow
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      activeDuty <= DTP_COUNT_ZERO;
    end else if (underflow) begin
      activeDuty <= dutyBuffer;
    end
  end

  // Sticky flag; a new underflow beats a clearing write
  // Writing one is ignored, so a read-modify-write cannot lose an event
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      underflowFlag <= 1'b0;
    end else if (underflow) begin
      underflowFlag <= 1'b1;
    end else if (wrFlag && !writedata[DTP_IRQ_BIT]) begin
      underflowFlag <= 1'b0;
    end
  end

  // Request needs the flag and both enables
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      underflowIrq <= 1'b0;
    end else begin
      underflowIrq <= underflowFlag && underflowIrqEnable &&
                      globalIrqEnable;
    end
  end

  // Timer toggle output flips on every underflow
  // Level is kept across a stop so the pad does not jump
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      toggleLevel <= 1'b0;
    end else if (underflow) begin
      toggleLevel <= !toggleLevel;
    end
  end

  // Buzzer divider; source is prescaler output or timer underflow
  // Divider and level restart from zero whenever the buzzer is enabled
  assign buzzerSourceTick = buzzerControl[DTP_BZ_TIMER_SRC] ?
                            underflow : prescaleTick;
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      buzzerCount <= 8'h00;
      buzzerLevel <= 1'b0;
    end else if (!buzzerControl[DTP_BZ_ENABLE]) begin
      buzzerCount <= 8'h00;
      buzzerLevel <= 1'b0;
    end else if (buzzerSourceTick) begin
      buzzerCount <= buzzerCount + 8'h01;
      if (divTick(buzzerCount, buzzerControl[2:0])) begin
        buzzerLevel <= !buzzerLevel;
      end
    end
  end

  // Active while count is below duty, so zero duty is never active
  assign pwmLevel = (count < activeDuty) ^
                    timerControlOne[DTP_C1_PWM_LOW];

  // Pad drivers, registered so every pad comes from a flip-flop
  // Costs one clock of lag but keeps pads free of decode glitches
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      portBPin4 <= '{level: 1'b0, enable: 1'b0};
      portBPin1 <= '{level: 1'b0, enable: 1'b0};
      portBPin3 <= '{level: 1'b0, enable: 1'b0};
    end else begin
      if (timerControlOne[DTP_C1_TOGGLE_EN]) begin
        portBPin4 <= '{level: toggleLevel, enable: 1'b1};
      end else if (timerControlOne[DTP_C1_PWM_EN] && !padOption) begin
        portBPin4 <= '{level: pwmLevel, enable: 1'b1};
      end else begin
        portBPin4 <= '{level: 1'b0, enable: 1'b0};
      end
      if (timerControlOne[DTP_C1_PWM_EN] && padOption) begin
        portBPin1 <= '{level: pwmLevel, enable: 1'b1};
      end else begin
        portBPin1 <= '{level: 1'b0, enable: 1'b0};
      end
      if (comparatorOutEnable) begin
        portBPin3 <= '{level: comparatorOut, enable: 1'b1};
      end else if (buzzerControl[DTP_BZ_ENABLE]) begin
        portBPin3 <= '{level: buzzerLevel, enable: 1'b1};
      end else begin
        portBPin3 <= '{level: 1'b0, enable: 1'b0};
      end
    end
  end

  // Read data latched while waitrequest is still high
  // So it already stands on the edge where waitrequest is seen low
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      readdata <= 32'h0000_0000;
    end else if (read && waitrequest) begin
      if (address == DTP_OFF_CTRL_ONE) begin
        readdata <= {24'h000000, timerControlOne};
      end else if (address == DTP_OFF_CTRL_TWO) begin
        readdata <= {24'h000000, timerControlTwo};
      end else if (address == DTP_OFF_UPPER) begin
        readdata <= {24'h000000, upperBitsRegister};
      end else if (address == DTP_OFF_RELOAD_LO) begin
        readdata <= {22'h0, count};
      end else if (address == DTP_OFF_DUTY_LO) begin
        readdata <= {24'h000000, pwmDutyLow};
      end else if (address == DTP_OFF_PRESCALE) begin
        readdata <= {24'h000000, prescaleCount};
      end else if (address == DTP_OFF_BUZZER) begin
        readdata <= {24'h000000, buzzerControl};
      end else if (address == DTP_OFF_IRQ_FLAG) begin
        readdata <= {28'h0000000, underflowFlag, 3'h0};
      end else if (address == DTP_OFF_IRQ_EN) begin
        readdata <= {28'h0000000, underflowIrqEnable, 3'h0};
      end else if (address == DTP_OFF_PROC_TWO) begin
        readdata <= {24'h000000, globalIrqEnable, 7'h00};
      end else if (address == DTP_OFF_PAD_OPT) begin
        readdata <= {31'h0, padOption};
      end else begin
        readdata <= 32'h0000_0000; // Unmapped reads as zero
      end
    end
  end

endmodule

// ### sim/dtp_pin_partner.sv
// Far side model: drives single pulses onto the external count pin
`timescale 1ns/1ps
module dtp_pin_partner (
  input  wire logic clock,
  input  wire logic pulseGo,
  output logic      externalCountClock
);
  logic [4:0] hold = 5'h00;
  // Pin rests low between pulses, so no stray edge reaches the timer
  assign externalCountClock = (hold != 5'h00);
  // Each request gives one high pulse sixteen clocks wide
  always @(posedge clock) begin
    if (pulseGo) hold <= 5'h10;
    else if (hold != 5'h00) hold <= hold - 5'h01;
  end
endmodule

// ### sim/dtp_timer_assertions.sv
// Concurrent checks on the timer's bus, request and pad ports
`timescale 1ns/1ps
module dtp_timer_checker
  import dtp_pkg::*;
(
  input wire logic        clock,
  input wire logic        reset,
  input wire logic [5:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [3:0]  byteenable,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  input wire logic        comparatorOutEnable,
  input wire logic        comparatorOut,
  input wire dtp_pad_type portBPin1,
  input wire dtp_pad_type portBPin3,
  input wire logic        underflowIrq
);
  logic       pwmOn, pinOpt, bzOn, global_irq_enable, irqEn;
  logic [1:0] settle;
  logic       take;
  assign take = write && !waitrequest && byteenable[0];
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // Shadow of control bits; pads lag an accepted write by two edges
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      {pwmOn, pinOpt, bzOn, global_irq_enable, irqEn} <= 5'h00;
    end else if (take) begin
      if (address == DTP_OFF_CTRL_ONE) pwmOn <= writedata[DTP_C1_PWM_EN];
      if (address == DTP_OFF_PAD_OPT) pinOpt <= writedata[0];
      if (address == DTP_OFF_BUZZER) bzOn <= writedata[DTP_BZ_ENABLE];
      if (address == DTP_OFF_PROC_TWO) global_irq_enable <= writedata[DTP_GIE_BIT];
      if (address == DTP_OFF_IRQ_EN) irqEn <= writedata[DTP_IRQ_BIT];
    end
  end
  // Cycles since the last accepted write, saturating
  always_ff @(posedge clock or posedge reset) begin
    if (reset) settle <= 2'h3;
    else if (take) settle <= 2'h0;
    else if (settle != 2'h3) settle <= settle + 2'h1;
  end
  a_wait_once: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_wait_answer: assert property ((read || write) && waitrequest
    |=> !waitrequest) else $error("request not answered in one cycle");
  a_wait_idle: assert property (!read && !write |=> waitrequest)
    else $error("waitrequest low without a request");
  a_unmapped_zero: assert property (read && !waitrequest
    && address > DTP_OFF_PAD_OPT |-> readdata == 32'h0)
    else $error("unmapped read not zero");
  a_reset_quiet: assert property ($fell(reset)
    |-> waitrequest && !underflowIrq) else $error("busy after reset");
  a_irq_gated: assert property (underflowIrq
    |-> (global_irq_enable || $past(global_irq_enable)) && (irqEn || $past(irqEn)))
    else $error("request raised without both enables");
  a_pwm_pad: assert property (settle == 2'h3
    |-> portBPin1.enable == (pwmOn && pinOpt))
    else $error("alternate pad direction wrong");
  a_buzzer_pad: assert property (settle == 2'h3 && !comparatorOutEnable
    && !$past(comparatorOutEnable) |-> portBPin3.enable == bzOn)
    else $error("buzzer pad direction wrong");
  a_compare_wins: assert property (comparatorOutEnable
    && $past(comparatorOutEnable) && $past(comparatorOutEnable, 2)
    && comparatorOut == $past(comparatorOut)
    && comparatorOut == $past(comparatorOut, 2)
    |-> portBPin3.enable && portBPin3.level == comparatorOut)
    else $error("comparator does not own buzzer pad");
endmodule
bind dtp_down_timer_pwm_buzzer dtp_timer_checker dtp_timer_checker_inst (
  .clock(clock), .reset(reset), .address(address), .read(read),
  .write(write), .byteenable(byteenable), .writedata(writedata),
  .readdata(readdata), .waitrequest(waitrequest),
  .comparatorOutEnable(comparatorOutEnable),
  .comparatorOut(comparatorOut), .portBPin1(portBPin1),
  .portBPin3(portBPin3), .underflowIrq(underflowIrq));

// ### sim/dtp_tb.sv
// Self-checking bench for the down timer with PWM and buzzer
`timescale 1ns/1ps
module tb
  import dtp_pkg::*;
();
  logic        clock = 1'b0;
  logic        reset = 1'b1;
  logic [5:0]  address = 6'h00;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [3:0]  byteenable = 4'h0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic        waitrequest, externalCountClock, underflowIrq;
  logic        comparatorOutEnable = 1'b0;
  logic        comparatorOut = 1'b0;
  logic        pulseGo = 1'b0;
  dtp_pad_type portBPin4, portBPin1, portBPin3;
  int          fails = 0;
  int          total_checks = 0;
  int          cycles = 0;

  dtp_down_timer_pwm_buzzer dtp_down_timer_pwm_buzzer_inst (
    .clock(clock), .reset(reset), .address(address), .read(read),
    .write(write), .byteenable(byteenable), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest),
    .externalCountClock(externalCountClock),
    .comparatorOutEnable(comparatorOutEnable),
    .comparatorOut(comparatorOut), .portBPin4(portBPin4),
    .portBPin1(portBPin1), .portBPin3(portBPin3),
    .underflowIrq(underflowIrq));
  dtp_pin_partner dtp_pin_partner_inst (.clock(clock), .pulseGo(pulseGo),
    .externalCountClock(externalCountClock));

  initial forever #12.5 clock = ~clock;
  // Cut a hung run short
  always @(posedge clock) begin
    cycles++;
    if (cycles == 60000) begin
      fails++;
      finish_test();
    end
  end

  task automatic finish_test();
    if (fails == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(string s, logic [31:0] seen, logic [31:0] e);
    total_checks++;
    if (seen !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", s, e, seen);
    end
  endtask
  // One Avalon cycle; request held until waitrequest is seen low
  task automatic bus(logic w, logic [5:0] a, logic [7:0] d,
                     output logic [31:0] q);
    address <= a;
    writedata <= {24'h0, d};
    byteenable <= 4'h1;
    write <= w;
    read <= !w;
    @(posedge clock);
    while (waitrequest !== 1'b0) begin
      @(posedge clock);
    end
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
    @(posedge clock);
  endtask
  task automatic wr(logic [5:0] a, logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(logic [5:0] a, output logic [31:0] q);
    bus(1'b0, a, 8'h00, q);
  endtask
  task automatic exp_rd(string s, logic [5:0] a, logic [31:0] m, e);
    logic [31:0] q;
    rd(a, q);
    check(s, q & m, e);
  endtask
  function automatic logic pad(int s);
    return s == 4 ? portBPin4.level : s == 1 ? portBPin1.level
                                             : portBPin3.level;
  endfunction
  // Cycles between two pad changes, after skipping the first change
  // Settles first so a tick of the old setting is never measured
  task automatic period(int s, output int p);
    logic v;
    int n;
    repeat (2) @(posedge clock);
    n = 0;
    v = pad(s);
    while (pad(s) === v && n < 999) begin
      @(posedge clock);
      n++;
    end
    v = pad(s);
    p = 0;
    while (pad(s) === v && p < 999) begin
      @(posedge clock);
      p++;
    end
  endtask
  task automatic highs(int s, int n, output int h);
    h = 0;
    repeat (n) begin
      @(posedge clock);
      if (pad(s) === 1'b1) h++;
    end
  endtask

  // Reset values, unmapped place, stopped load and count held while stopped
  task automatic test_regs();
    exp_rd("ctrl two", DTP_OFF_CTRL_TWO, 32'hff, DTP_RST_CTRL_TWO);
    exp_rd("ctrl one", DTP_OFF_CTRL_ONE, 32'hff, 32'h0);
    wr(6'h2c, 8'h5a);
    exp_rd("unmapped", 6'h2c, 32'hffffffff, 32'h0);
    wr(DTP_OFF_UPPER, 8'h10);
    wr(DTP_OFF_RELOAD_LO, 8'h23);
    exp_rd("loaded", DTP_OFF_RELOAD_LO, 32'h3ff, 32'h123);
    repeat (10) @(posedge clock);
    exp_rd("stopped", DTP_OFF_RELOAD_LO, 32'h3ff, 32'h123);
  endtask
  // One-shot run; flag outlives a write of one, the global gate drops the request
  task automatic test_oneshot();
    wr(DTP_OFF_IRQ_EN, 8'h08);
    wr(DTP_OFF_PROC_TWO, 8'h80);
    wr(DTP_OFF_UPPER, 8'h00);
    wr(DTP_OFF_RELOAD_LO, 8'h03);
    wr(DTP_OFF_CTRL_ONE, 8'h05);
    repeat (20) @(posedge clock);
    exp_rd("os stop", DTP_OFF_CTRL_ONE, 32'h07, 32'h04);
    exp_rd("os count", DTP_OFF_RELOAD_LO, 32'h3ff, 32'h3);
    check("irq", underflowIrq, 1'b1);
    wr(DTP_OFF_IRQ_FLAG, 8'hff);
    exp_rd("flag kept", DTP_OFF_IRQ_FLAG, 32'h08, 32'h08);
    wr(DTP_OFF_PROC_TWO, 8'h00);
    repeat (3) @(posedge clock);
    check("gie off", underflowIrq, 1'b0);
    wr(DTP_OFF_IRQ_FLAG, 8'h00);
    exp_rd("flag clear", DTP_OFF_IRQ_FLAG, 32'h08, 32'h00);
    wr(DTP_OFF_PROC_TWO, 8'h80);
  endtask
  // Restart from initial value or top; running reload waits
  task automatic test_modes();
    logic [31:0] q;
    wr(DTP_OFF_RELOAD_LO, 8'h05);
    wr(DTP_OFF_CTRL_ONE, 8'h03);
    repeat (10) @(posedge clock);
    rd(DTP_OFF_RELOAD_LO, q);
    check("reload mode", q[9:0] <= 10'h5, 1'b1);
    wr(DTP_OFF_CTRL_ONE, 8'h01);
    repeat (10) @(posedge clock);
    rd(DTP_OFF_RELOAD_LO, q);
    check("top mode", q[9:0] > 10'h3e0, 1'b1);
    wr(DTP_OFF_RELOAD_LO, 8'h07);
    rd(DTP_OFF_RELOAD_LO, q);
    check("deferred", q[9:0] > 10'h3d0, 1'b1);
  endtask
  // Every prescaler rate as the toggle period on the shared pad
  task automatic test_prescaler();
    int p;
    logic [31:0] a, b;
    wr(DTP_OFF_CTRL_ONE, 8'h00);
    wr(DTP_OFF_RELOAD_LO, 8'h00);
    wr(DTP_OFF_CTRL_ONE, 8'ha3);
    for (int r = 0; r < 8; r++) begin
      wr(DTP_OFF_CTRL_TWO, 8'(r));
      period(4, p);
      check("prescale", p, 2 << r);
    end
    check("toggle pad", portBPin4.enable, 1'b1);
    rd(DTP_OFF_PRESCALE, a);
    rd(DTP_OFF_PRESCALE, b);
    check("prescale moves", a != b, 1'b1);
    wr(DTP_OFF_CTRL_TWO, 8'h08);
    period(4, p);
    check("bypass", p, 1);
  endtask
  // One pin pulse; the edge mode decides when the toggle lands
  task automatic test_ext(logic [7:0] c, logic early);
    logic v;
    wr(DTP_OFF_CTRL_TWO, c);
    repeat (3) @(posedge clock);
    v = portBPin4.level;
    pulseGo <= 1'b1;
    @(posedge clock);
    pulseGo <= 1'b0;
    repeat (10) @(posedge clock);
    check("edge early", portBPin4.level ^ v, early);
    repeat (20) @(posedge clock);
    check("edge late", portBPin4.level ^ v, 1'b1);
  endtask
  // Duty, polarity and zero duty on the alternate pad
  task automatic test_pwm();
    int h;
    wr(DTP_OFF_CTRL_TWO, 8'h08);
    wr(DTP_OFF_PAD_OPT, 8'h01);
    wr(DTP_OFF_RELOAD_LO, 8'h09);
    wr(DTP_OFF_DUTY_LO, 8'h03);
    wr(DTP_OFF_CTRL_ONE, 8'h83);
    repeat (30) @(posedge clock);
    highs(1, 20, h);
    check("duty high", h, 6);
    wr(DTP_OFF_CTRL_ONE, 8'hc3);
    highs(1, 20, h);
    check("active low", h, 14);
    wr(DTP_OFF_DUTY_LO, 8'h00);
    repeat (30) @(posedge clock);
    highs(1, 20, h);
    check("duty zero", h, 20);
  endtask
  // Buzzer dividers, both sources, comparator taking the pad
  task automatic test_buzzer();
    int p;
    wr(DTP_OFF_RELOAD_LO, 8'h01);
    for (int n = 0; n < 8; n++) begin
      wr(DTP_OFF_BUZZER, 8'h80 | 8'(n));
      period(3, p);
      check("buzzer div", p, 2 << n);
    end
    wr(DTP_OFF_BUZZER, 8'h88);
    period(3, p);
    check("buzzer timer", p, 4);
    comparatorOut <= 1'b1;
    comparatorOutEnable <= 1'b1;
    repeat (4) @(posedge clock);
    check("comparator", portBPin3, 2'b11);
    comparatorOutEnable <= 1'b0;
    wr(DTP_OFF_BUZZER, 8'h00);
    repeat (3) @(posedge clock);
    check("buzzer off", portBPin3.enable, 1'b0);
  endtask

  // Main sequence
  initial begin
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    test_regs();
    test_oneshot();
    test_modes();
    test_prescaler();
    test_ext(8'h28, 1'b1);
    test_ext(8'h38, 1'b0);
    test_pwm();
    test_buzzer();
    finish_test();
  end
endmodule
